//--- shared/mic_defines.svh
/*
 * Register offsets, field positions, reset values and timing counts of the iron correction block.
 * Assumes it is included by bare name before any use of its macros.
 */
`ifndef MIC_DEFINES_SVH
`define MIC_DEFINES_SVH

// ----------------------------------------------------------------------------
// Main bank offsets.
// ----------------------------------------------------------------------------
`define MIC_OFF_BANK_ACCESS 8'h01
`define MIC_OFF_AXIS_CTRL 8'h18
`define MIC_OFF_FUNC_CTRL 8'h19
`define MIC_OFF_MASTER_CFG 8'h1A
`define MIC_OFF_CAL_FIRST 8'h2E
`define MIC_OFF_CAL_LAST 8'h33
`define MIC_OFF_UNCAL_FIRST 8'h4D
`define MIC_OFF_UNCAL_LAST 8'h52
`define MIC_OFF_FUNC_STATUS 8'h53
`define MIC_OFF_LATCH_CFG 8'h58
`define MIC_OFF_IRQ2_ROUTE 8'h5F
`define MIC_OFF_RAW_FIRST 8'h66
`define MIC_OFF_RAW_LAST 8'h6B

// ----------------------------------------------------------------------------
// Embedded bank offsets.
// ----------------------------------------------------------------------------
`define MIC_OFF_SLOT0_ADDR 8'h02
`define MIC_OFF_SLOT0_SUB 8'h03
`define MIC_OFF_SLOT0_SETUP 8'h04
`define MIC_OFF_SOFT_FIRST 8'h24
`define MIC_OFF_SOFT_LAST 8'h2C
`define MIC_OFF_HARD_FIRST 8'h2D
`define MIC_OFF_HARD_LAST 8'h32

// ----------------------------------------------------------------------------
// Field positions and reset values.
// ----------------------------------------------------------------------------
`define MIC_BIT_BANK_EN 7
`define MIC_BIT_SOFT_EN 2
`define MIC_BIT_EMBEDDED_FUNCTION_ENABLE 2
`define MIC_BIT_MASTER_ON 0
`define MIC_BIT_IRON_EN 4
`define MIC_BIT_HUB_TO_IRQ1 7
`define MIC_BIT_LATCH 0
`define MIC_BIT_IRON_TO_IRQ2 5
`define MIC_BIT_ST_HUB 0
`define MIC_BIT_ST_CORR 1
`define MIC_RST_BYTE 8'h00
`define MIC_FRAME_BYTES 6

// ----------------------------------------------------------------------------
// Timing.
// ----------------------------------------------------------------------------
`define MIC_CLK_HZ 25000000
`define MIC_FLAG_HOLD_HZ 100
`define MIC_FLAG_HOLD_CYCLES (`MIC_CLK_HZ / `MIC_FLAG_HOLD_HZ)

`endif

//--- shared/mic_pkg.sv
/*
 * Types shared by the iron correction block.
 * Assumes nothing of its surroundings.
 */
package mic_pkg;

    // ------------------------------------------------------------------------
    // Correction mode.
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        MIC_MODE_NONE = 3'b001,
        MIC_MODE_HARD = 3'b010,
        MIC_MODE_BOTH = 3'b100
    } mic_mode_t;

endpackage

//--- src/mic_iron_corr.sv
/*
 * Magnetometer hard-iron and soft-iron correction with its register bank and flags.
 * Assumes a single-cycle register port on clk and a slot 0 byte stream on aux_clk.
 */
// What this block does
// - No correction unless function enable set.
// - Soft and iron bits select correction mode.
// - Both mode gives calibrated and uncalibrated sets; hard mode gives calibrated only.
// - Three 16-bit two's-complement hard offsets.
// - Coefficients reachable only with bank access.
// - Nine sign-magnitude coefficients, LSB is 1/8.
// - Hub done flag; raw at 66h-6Bh.
// - Correction done flag after enabled computations.
// - Soft-only results at 4Dh-52h.
// - Calibrated results at 2Eh-33h.
// - Unlatched flags last 1/100 s.
// - Latched flags clear on status read.
// - Hub done routed to first pin.
// - Correction done routed to second pin.
// - Zero matrix yields zero results in both mode.
`timescale 1ns/1ps
`include "mic_defines.svh"
module mic_iron_corr #(
    parameter int unsigned FLAG_HOLD_CYCLES = `MIC_FLAG_HOLD_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic aux_clk,
    input wire logic aux_byte_valid,
    input wire logic [7:0] aux_byte,
    input wire logic aux_read_end,
    output logic master_on,
    output logic [7:0] slot0_target_address,
    output logic [7:0] slot0_target_register,
    output logic [2:0] slot0_read_count,
    output logic first_interrupt_pin,
    output logic second_interrupt_pin
);

    localparam int CW = $clog2(FLAG_HOLD_CYCLES + 1);

    generate
        if (FLAG_HOLD_CYCLES < 2) begin : g_bad_hold
            $error("FLAG_HOLD_CYCLES must be at least 2");
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Storage.
    // ------------------------------------------------------------------------
    logic [7:0] bank_access_r, slot0_addr_r, slot0_sub_r, slot0_setup_r;
    logic [7:0] axis_ctrl_r, func_ctrl_r, master_cfg_r, latch_cfg_r, irq2_route_r;
    logic [7:0] soft_r [0:8];
    logic [7:0] hard_r [0:5];
    logic [7:0] raw_r [0:5];
    logic [7:0] cal_r [0:5];
    logic [7:0] uncal_r [0:5];
    logic req_s1_r, req_s2_r, req_s3_r;
    logic hub_evt_r, corr_evt_r;
    logic [1:0] flag_r;
    logic [CW-1:0] hold_cnt_r [0:1];
    logic link_req;
    logic [47:0] link_data;
    logic bank_en, embedded_function_enable, latched, status_rd;
    logic [1:0] evt;
    mic_pkg::mic_mode_t mode;
    logic [15:0] raw_ax [0:2];
    logic [15:0] off_ax [0:2];
    logic [15:0] hard_ax [0:2];
    logic [50:0] diff_vec, raw_vec;
    logic [71:0] mat_flat;
    logic [47:0] soft_cal, soft_uncal, cal_nxt, raw_flat;
    logic [7:0] rd_nxt, status_byte;

    function automatic logic [15:0] sat16(input logic [16:0] v);
        if (v[16] != v[15]) begin
            return v[16] ? 16'h8000 : 16'h7FFF;
        end
        return v[15:0];
    endfunction

    assign bank_en = bank_access_r[`MIC_BIT_BANK_EN];
    assign embedded_function_enable = func_ctrl_r[`MIC_BIT_EMBEDDED_FUNCTION_ENABLE];
    assign latched = latch_cfg_r[`MIC_BIT_LATCH];
    assign status_rd = reg_rd && !bank_en && reg_addr == `MIC_OFF_FUNC_STATUS;
    assign evt = {corr_evt_r, hub_evt_r};

    // ------------------------------------------------------------------------
    // Link capture and crossing.
    // ------------------------------------------------------------------------
    mic_link_capture u_link (
        .aux_clk(aux_clk),
        .sys_rst(sys_rst),
        .aux_byte_valid(aux_byte_valid),
        .aux_byte(aux_byte),
        .aux_read_end(aux_read_end),
        .ack_tgl(req_s3_r),
        .req_tgl(link_req),
        .frame_data(link_data)
    );

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            req_s1_r <= 1'b0;
            req_s2_r <= 1'b0;
            req_s3_r <= 1'b0;
        end else begin
            req_s1_r <= link_req;
            req_s2_r <= req_s1_r;
            req_s3_r <= req_s2_r;
        end
    end

    // ------------------------------------------------------------------------
    // Correction arithmetic.
    // ------------------------------------------------------------------------
    always_comb begin
        if (!master_cfg_r[`MIC_BIT_IRON_EN]) begin
            mode = mic_pkg::MIC_MODE_NONE;
        end else if (axis_ctrl_r[`MIC_BIT_SOFT_EN]) begin
            mode = mic_pkg::MIC_MODE_BOTH;
        end else begin
            mode = mic_pkg::MIC_MODE_HARD;
        end
    end

    genvar a;
    generate
        for (a = 0; a < 3; a = a + 1) begin : g_axis
            assign raw_ax[a] = {raw_r[2*a+1], raw_r[2*a]};
            assign off_ax[a] = {hard_r[2*a+1], hard_r[2*a]};
            assign raw_vec[17*a +: 17] = 17'($signed(raw_ax[a]));
            assign diff_vec[17*a +: 17] = 17'($signed(raw_ax[a])) - 17'($signed(off_ax[a]));
            assign hard_ax[a] = sat16(diff_vec[17*a +: 17]);
        end
    endgenerate

    assign raw_flat = {raw_ax[2], raw_ax[1], raw_ax[0]};

    always_comb begin
        for (int i = 0; i < 9; i++) begin
            mat_flat[8*i +: 8] = soft_r[i];
        end
    end

    mic_iron_math u_cal (
        .vec_in(diff_vec),
        .matrix_in(mat_flat),
        .res_out(soft_cal)
    );

    mic_iron_math u_uncal (
        .vec_in(raw_vec),
        .matrix_in(mat_flat),
        .res_out(soft_uncal)
    );

    always_comb begin
        case (mode)
            mic_pkg::MIC_MODE_NONE: cal_nxt = raw_flat;
            mic_pkg::MIC_MODE_HARD: cal_nxt = {hard_ax[2], hard_ax[1], hard_ax[0]};
            default: cal_nxt = soft_cal;
        endcase
    end

    // ------------------------------------------------------------------------
    // Sample and result registers.
    // ------------------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            hub_evt_r <= 1'b0;
            corr_evt_r <= 1'b0;
            for (int i = 0; i < 6; i++) begin
                raw_r[i] <= `MIC_RST_BYTE;
                cal_r[i] <= `MIC_RST_BYTE;
                uncal_r[i] <= `MIC_RST_BYTE;
            end
        end else begin
            hub_evt_r <= (req_s2_r != req_s3_r) && master_cfg_r[`MIC_BIT_MASTER_ON];
            corr_evt_r <= hub_evt_r && embedded_function_enable;
            for (int i = 0; i < 6; i++) begin
                if ((req_s2_r != req_s3_r) && master_cfg_r[`MIC_BIT_MASTER_ON]) begin
                    raw_r[i] <= link_data[8*i +: 8];
                end
                if (hub_evt_r && embedded_function_enable) begin
                    cal_r[i] <= cal_nxt[8*i +: 8];
                    if (mode == mic_pkg::MIC_MODE_BOTH) begin
                        uncal_r[i] <= soft_uncal[8*i +: 8];
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // Completion flags.
    // ------------------------------------------------------------------------
    genvar f;
    generate
        for (f = 0; f < 2; f = f + 1) begin : g_flag
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    flag_r[f] <= 1'b0;
                    hold_cnt_r[f] <= '0;
                end else if (evt[f]) begin
                    flag_r[f] <= 1'b1;
                    hold_cnt_r[f] <= CW'(FLAG_HOLD_CYCLES - 1);
                end else if (latched) begin
                    if (status_rd) begin
                        flag_r[f] <= 1'b0;
                    end
                end else if (hold_cnt_r[f] != '0) begin
                    hold_cnt_r[f] <= hold_cnt_r[f] - CW'(1);
                end else begin
                    flag_r[f] <= 1'b0;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Register writes.
    // ------------------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bank_access_r <= `MIC_RST_BYTE;
            slot0_addr_r <= `MIC_RST_BYTE;
            slot0_sub_r <= `MIC_RST_BYTE;
            slot0_setup_r <= `MIC_RST_BYTE;
            axis_ctrl_r <= `MIC_RST_BYTE;
            func_ctrl_r <= `MIC_RST_BYTE;
            master_cfg_r <= `MIC_RST_BYTE;
            latch_cfg_r <= `MIC_RST_BYTE;
            irq2_route_r <= `MIC_RST_BYTE;
            for (int i = 0; i < 9; i++) begin
                soft_r[i] <= `MIC_RST_BYTE;
            end
            for (int i = 0; i < 6; i++) begin
                hard_r[i] <= `MIC_RST_BYTE;
            end
        end else if (reg_wr) begin
            if (reg_addr == `MIC_OFF_BANK_ACCESS) begin
                bank_access_r <= reg_wdata;
            end else if (bank_en && reg_addr >= `MIC_OFF_SOFT_FIRST
                         && reg_addr <= `MIC_OFF_SOFT_LAST) begin
                soft_r[4'(reg_addr - `MIC_OFF_SOFT_FIRST)] <= reg_wdata;
            end else if (bank_en && reg_addr >= `MIC_OFF_HARD_FIRST
                         && reg_addr <= `MIC_OFF_HARD_LAST) begin
                hard_r[3'(reg_addr - `MIC_OFF_HARD_FIRST)] <= reg_wdata;
            end else if (bank_en && reg_addr == `MIC_OFF_SLOT0_ADDR) begin
                slot0_addr_r <= reg_wdata;
            end else if (bank_en && reg_addr == `MIC_OFF_SLOT0_SUB) begin
                slot0_sub_r <= reg_wdata;
            end else if (bank_en && reg_addr == `MIC_OFF_SLOT0_SETUP) begin
                slot0_setup_r <= reg_wdata;
            end else if (bank_en) begin
                bank_access_r <= bank_access_r;
            end else if (reg_addr == `MIC_OFF_AXIS_CTRL) begin
                axis_ctrl_r <= reg_wdata;
            end else if (reg_addr == `MIC_OFF_FUNC_CTRL) begin
                func_ctrl_r <= reg_wdata;
            end else if (reg_addr == `MIC_OFF_MASTER_CFG) begin
                master_cfg_r <= reg_wdata;
            end else if (reg_addr == `MIC_OFF_LATCH_CFG) begin
                latch_cfg_r <= reg_wdata;
            end else if (reg_addr == `MIC_OFF_IRQ2_ROUTE) begin
                irq2_route_r <= reg_wdata;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Register reads.
    // ------------------------------------------------------------------------
    always_comb begin
        status_byte = 8'h00;
        status_byte[`MIC_BIT_ST_HUB] = flag_r[0];
        status_byte[`MIC_BIT_ST_CORR] = flag_r[1];
        rd_nxt = 8'h00;
        if (reg_addr == `MIC_OFF_BANK_ACCESS) begin
            rd_nxt = bank_access_r;
        end else if (bank_en && reg_addr >= `MIC_OFF_SOFT_FIRST
                     && reg_addr <= `MIC_OFF_SOFT_LAST) begin
            rd_nxt = soft_r[4'(reg_addr - `MIC_OFF_SOFT_FIRST)];
        end else if (bank_en && reg_addr >= `MIC_OFF_HARD_FIRST
                     && reg_addr <= `MIC_OFF_HARD_LAST) begin
            rd_nxt = hard_r[3'(reg_addr - `MIC_OFF_HARD_FIRST)];
        end else if (bank_en && reg_addr == `MIC_OFF_SLOT0_ADDR) begin
            rd_nxt = slot0_addr_r;
        end else if (bank_en && reg_addr == `MIC_OFF_SLOT0_SUB) begin
            rd_nxt = slot0_sub_r;
        end else if (bank_en && reg_addr == `MIC_OFF_SLOT0_SETUP) begin
            rd_nxt = slot0_setup_r;
        end else if (bank_en) begin
            rd_nxt = 8'h00;
        end else if (reg_addr == `MIC_OFF_AXIS_CTRL) begin
            rd_nxt = axis_ctrl_r;
        end else if (reg_addr == `MIC_OFF_FUNC_CTRL) begin
            rd_nxt = func_ctrl_r;
        end else if (reg_addr == `MIC_OFF_MASTER_CFG) begin
            rd_nxt = master_cfg_r;
        end else if (reg_addr == `MIC_OFF_LATCH_CFG) begin
            rd_nxt = latch_cfg_r;
        end else if (reg_addr == `MIC_OFF_IRQ2_ROUTE) begin
            rd_nxt = irq2_route_r;
        end else if (reg_addr == `MIC_OFF_FUNC_STATUS) begin
            rd_nxt = status_byte;
        end else if (reg_addr >= `MIC_OFF_CAL_FIRST && reg_addr <= `MIC_OFF_CAL_LAST) begin
            rd_nxt = cal_r[3'(reg_addr - `MIC_OFF_CAL_FIRST)];
        end else if (reg_addr >= `MIC_OFF_UNCAL_FIRST && reg_addr <= `MIC_OFF_UNCAL_LAST) begin
            rd_nxt = uncal_r[3'(reg_addr - `MIC_OFF_UNCAL_FIRST)];
        end else if (reg_addr >= `MIC_OFF_RAW_FIRST && reg_addr <= `MIC_OFF_RAW_LAST) begin
            rd_nxt = raw_r[3'(reg_addr - `MIC_OFF_RAW_FIRST)];
        end
    end

    // ------------------------------------------------------------------------
    // Output flip-flops.
    // ------------------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
            master_on <= 1'b0;
            slot0_target_address <= 8'h00;
            slot0_target_register <= 8'h00;
            slot0_read_count <= 3'd0;
            first_interrupt_pin <= 1'b0;
            second_interrupt_pin <= 1'b0;
        end else begin
            if (reg_rd) begin
                reg_rdata <= rd_nxt;
            end
            master_on <= master_cfg_r[`MIC_BIT_MASTER_ON];
            slot0_target_address <= slot0_addr_r;
            slot0_target_register <= slot0_sub_r;
            slot0_read_count <= slot0_setup_r[2:0];
            first_interrupt_pin <= flag_r[0] && master_cfg_r[`MIC_BIT_HUB_TO_IRQ1];
            second_interrupt_pin <= flag_r[1] && irq2_route_r[`MIC_BIT_IRON_TO_IRQ2];
        end
    end

    // ------------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    chk_corr_needs_enable: assert property ($rose(flag_r[1]) |-> $past(embedded_function_enable, 2))
        else $error("correction flag rose with functions disabled");
    chk_hub_then_corr: assert property (hub_evt_r && embedded_function_enable |=> corr_evt_r ##1 flag_r[1])
        else $error("correction did not follow hub completion");
    chk_raw_loaded: assert property (hub_evt_r |-> raw_flat == $past(link_data))
        else $error("raw sample not loaded from link");
    chk_mode_none: assert property (corr_evt_r && $past(mode) == mic_pkg::MIC_MODE_NONE
        |-> {cal_r[1], cal_r[0]} == raw_ax[0])
        else $error("uncorrected output differs from raw");
    chk_zero_matrix: assert property (corr_evt_r && $past(mode) == mic_pkg::MIC_MODE_BOTH
        && $past(mat_flat) == '0 |-> {cal_r[5], uncal_r[5], cal_r[0], uncal_r[0]} == '0)
        else $error("zero matrix gave nonzero result");
    chk_latch_hold: assert property (latched && flag_r[0] && !status_rd |=> flag_r[0])
        else $error("latched flag dropped without status read");
    chk_latch_clear: assert property (latched && status_rd && !evt[1] |=> !flag_r[1])
        else $error("status read did not clear latched flag");
    chk_pulse_end: assert property (!latched && flag_r[0] && hold_cnt_r[0] == '0 && !evt[0]
        |=> !flag_r[0])
        else $error("unlatched flag outlived its period");
    chk_irq1_route: assert property (hub_evt_r && master_cfg_r[`MIC_BIT_HUB_TO_IRQ1]
        ##1 master_cfg_r[`MIC_BIT_HUB_TO_IRQ1] |=> first_interrupt_pin)
        else $error("hub done not routed to first pin");
    chk_bank_gate: assert property (reg_wr && !bank_en |=> $stable(mat_flat))
        else $error("coefficient changed with bank closed");

endmodule // mic_iron_corr

//--- src/mic_iron_math.sv
/*
 * Soft matrix product of a three-axis vector, scaled by one eighth and saturated to 16 bits.
 * Assumes a 17-bit signed vector per axis and sign-magnitude coefficients, row-major.
 */
`timescale 1ns/1ps
module mic_iron_math (
    input wire logic [50:0] vec_in,
    input wire logic [71:0] matrix_in,
    output logic [47:0] res_out
);

    function automatic logic signed [8:0] coef(input logic [7:0] b);
        logic signed [8:0] mag;
        mag = $signed({2'b00, b[6:0]});
        return b[7] ? -mag : mag;
    endfunction

    genvar r;
    generate
        for (r = 0; r < 3; r = r + 1) begin : g_row
            logic signed [27:0] acc;
            logic signed [27:0] scaled;
            always_comb begin
                acc = '0;
                for (int c = 0; c < 3; c++) begin
                    acc = acc + 28'(coef(matrix_in[8*(3*r+c) +: 8])
                        * $signed(vec_in[17*c +: 17]));
                end
                scaled = acc >>> 3;
                if (scaled > 28'sd32767) begin
                    res_out[16*r +: 16] = 16'h7FFF;
                end else if (scaled < -28'sd32768) begin
                    res_out[16*r +: 16] = 16'h8000;
                end else begin
                    res_out[16*r +: 16] = scaled[15:0];
                end
            end
        end
    endgenerate

endmodule // mic_iron_math

//--- src/mic_link_capture.sv
/*
 * Link-side capture of the six bytes read from slot 0, handed over by toggle handshake.
 * Assumes the byte strobes and read end come from logic on aux_clk.
 */
`timescale 1ns/1ps
`include "mic_defines.svh"
module mic_link_capture (
    input wire logic aux_clk,
    input wire logic sys_rst,
    input wire logic aux_byte_valid,
    input wire logic [7:0] aux_byte,
    input wire logic aux_read_end,
    input wire logic ack_tgl,
    output logic req_tgl,
    output logic [47:0] frame_data
);

    logic [2:0] cnt_r;
    logic [47:0] buf_r;
    logic ack_s1_r;
    logic ack_s2_r;

    // ------------------------------------------------------------------------
    // Acknowledge synchroniser.
    // ------------------------------------------------------------------------
    always_ff @(posedge aux_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ack_s1_r <= 1'b0;
            ack_s2_r <= 1'b0;
        end else begin
            ack_s1_r <= ack_tgl;
            ack_s2_r <= ack_s1_r;
        end
    end

    // ------------------------------------------------------------------------
    // Byte collection and hand-over.
    // ------------------------------------------------------------------------
    always_ff @(posedge aux_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_r <= 3'd0;
            buf_r <= '0;
            req_tgl <= 1'b0;
            frame_data <= '0;
        end else if (aux_read_end) begin
            cnt_r <= 3'd0;
            if (cnt_r == 3'(`MIC_FRAME_BYTES) && req_tgl == ack_s2_r) begin
                frame_data <= buf_r;
                req_tgl <= ~req_tgl;
            end
        end else if (aux_byte_valid && cnt_r < 3'(`MIC_FRAME_BYTES)) begin
            buf_r[8*cnt_r +: 8] <= aux_byte;
            cnt_r <= cnt_r + 3'd1;
        end
    end

endmodule // mic_link_capture

//--- tb/mic_mag_model.sv
/* Slot 0 magnetometer on the link: six bytes, then an end pulse.
   Assumes the bench calls send and that the link clock stops between frames. */
`timescale 1ns/1ps
module mic_mag_model (
    input wire logic sys_rst,
    output logic aux_clk,
    output logic aux_byte_valid,
    output logic [7:0] aux_byte,
    output logic aux_read_end
);
    logic busy = 0;
    initial begin
        aux_clk = 0;
        aux_byte_valid = 0;
        aux_byte = 8'h00;
        aux_read_end = 0;
        forever begin
            if (sys_rst || busy) #6 aux_clk = ~aux_clk;
            else @(sys_rst or busy);
        end
    end
    task automatic send(input logic [47:0] d);
        busy = 1;
        for (int k = 0; k < 6; k++) begin
            @(posedge aux_clk) aux_byte_valid <= 1;
            aux_byte <= d[8*k+:8];
        end
        @(posedge aux_clk) aux_byte_valid <= 0;
        aux_read_end <= 1;
        aux_byte <= ~aux_byte;
        @(posedge aux_clk) aux_read_end <= 0;
        repeat (40) @(posedge aux_clk);
        busy = 0;
    endtask
endmodule // mic_mag_model

//--- tb/tb.sv
/* Register-level bench of the iron correction block.
   Assumes the shared header, the design and the link model are compiled first. */
`timescale 1ns/1ps
module tb;
    logic clk, sys_rst, reg_wr, reg_rd, aux_clk, aux_byte_valid, aux_read_end;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, aux_byte, slot0_target_address;
    logic [7:0] slot0_target_register;
    logic [2:0] slot0_read_count;
    logic master_on, first_interrupt_pin, second_interrupt_pin;
    int bad_count = 0;
    int n_tests = 0;
    mic_iron_corr #(.FLAG_HOLD_CYCLES(20)) i_mic_iron_corr (.clk, .sys_rst, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .aux_clk, .aux_byte_valid, .aux_byte,
        .aux_read_end, .master_on, .slot0_target_address, .slot0_target_register,
        .slot0_read_count, .first_interrupt_pin, .second_interrupt_pin);
    mic_mag_model i_mic_mag_model (.sys_rst, .aux_clk, .aux_byte_valid, .aux_byte,
        .aux_read_end);
    task automatic print_verdict();
        $display("tests %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        n_tests++;
        if (s !== e) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) reg_wr <= 1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk) reg_wr <= 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk) reg_rd <= 1;
        reg_addr <= a;
        @(posedge clk) reg_rd <= 0;
        #1 chk(reg_rdata, e);
    endtask
    task automatic rdv(input logic [7:0] a, input logic [47:0] e);
        for (int k = 0; k < 6; k++) rd(a + 8'(k), e[8*k+:8]);
    endtask
    task automatic frame(input logic [47:0] d, input logic want2);
        i_mic_mag_model.send(d);
        for (int k = 0; k < 100 && want2 && !second_interrupt_pin; k++) @(posedge clk);
        repeat (3) @(posedge clk);
        chk({7'h00, second_interrupt_pin}, {7'h00, want2});
        if (second_interrupt_pin !== want2) print_verdict();
    endtask
    initial begin
        clk = 0;
        forever #20 clk = ~clk;
    end
    initial begin
        logic [47:0] off, raw;
        off = 48'hFFB4_0054_FF20;
        raw = 48'hFFF0_0010_0100;
        sys_rst = 1;
        reg_wr = 0;
        reg_rd = 0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        repeat (4) @(posedge clk);
        sys_rst <= 0;
        rd(8'h53, 8'h00);
        wr(8'h01, 8'h80);
        for (int k = 0; k < 9; k++) wr(8'h24 + 8'(k), (k % 4 == 0) ? 8'h08 : 8'h00);
        for (int k = 0; k < 6; k++) wr(8'h2D + 8'(k), off[8*k+:8]);
        wr(8'h02, 8'h2A);
        wr(8'h03, 8'h44);
        wr(8'h04, 8'h06);
        @(posedge clk);
        #1 chk({5'h00, slot0_read_count}, 8'h06);
        chk(slot0_target_address, 8'h2A);
        chk(slot0_target_register, 8'h44);
        rd(8'h28, 8'h08);
        rd(8'h31, 8'hB4);
        wr(8'h01, 8'h00);
        rd(8'h24, 8'h00);
        $display("test bank done");
        wr(8'h19, 8'h04);
        wr(8'h18, 8'h04);
        wr(8'h1A, 8'h91);
        wr(8'h5F, 8'h20);
        wr(8'h58, 8'h01);
        frame(raw, 1'b1);
        repeat (30) @(posedge clk);
        chk({6'h00, first_interrupt_pin, second_interrupt_pin}, 8'h03);
        chk({7'h00, master_on}, 8'h01);
        rdv(8'h66, raw);
        rdv(8'h2E, 48'h003C_FFBC_01E0);
        rdv(8'h4D, raw);
        rd(8'h53, 8'h03);
        rd(8'h53, 8'h00);
        $display("test both done");
        wr(8'h58, 8'h00);
        wr(8'h1A, 8'h11);
        wr(8'h18, 8'h00);
        frame(48'h0000_0000_0000, 1'b1);
        chk({7'h00, first_interrupt_pin}, 8'h00);
        rdv(8'h2E, 48'h004C_FFAC_00E0);
        rdv(8'h4D, raw);
        repeat (25) @(posedge clk);
        chk({7'h00, second_interrupt_pin}, 8'h00);
        $display("test hard done");
        wr(8'h19, 8'h00);
        frame(raw, 1'b0);
        rdv(8'h66, raw);
        rdv(8'h2E, 48'h004C_FFAC_00E0);
        wr(8'h19, 8'h04);
        wr(8'h1A, 8'h01);
        frame(48'h0000_0000_0000, 1'b1);
        frame(raw, 1'b1);
        rdv(8'h2E, raw);
        $display("test modes done");
        wr(8'h01, 8'h80);
        for (int k = 0; k < 9; k += 4) wr(8'h24 + 8'(k), 8'h00);
        wr(8'h01, 8'h00);
        wr(8'h1A, 8'h11);
        wr(8'h18, 8'h04);
        frame(raw, 1'b1);
        rdv(8'h2E, 48'h0000_0000_0000);
        rdv(8'h4D, 48'h0000_0000_0000);
        $display("test zero matrix done");
        print_verdict();
    end
endmodule // tb
